// [design/epl_link_partner.sv]
`timescale 1ns/100ps

module epl_link_partner (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [8:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic miim_rd_in,
  input wire logic miim_wr_in,
  input wire logic [4:0] miim_index_in,
  input wire logic [15:0] miim_wdata_in,
  output logic [15:0] miim_rdata_out,
  output logic miim_rvalid_out,
  input wire logic an_restart_in,
  input wire logic port0_duplex_input_in,
  input wire logic fullduplex_flowctl_latch_in,
  input wire logic duplex_pol_strap_in,
  input wire logic speed_strap_in,
  input wire logic manual_fc_strap_in,
  output logic an_complete_out,
  output logic lp_sym_pause_out,
  output logic lp_asym_pause_out
);

  // ----------------------------------------
  // Straps
  // ----------------------------------------
  logic [epl_pkg::STRAP_WIDTH-1:0] strap_raw;
  logic [epl_pkg::STRAP_WIDTH-1:0] strap;
  logic strap_capture;

  assign strap_raw = {manual_fc_strap_in, speed_strap_in, duplex_pol_strap_in,
                      fullduplex_flowctl_latch_in};

  epl_strap_latch #(
    .WIDTH(epl_pkg::STRAP_WIDTH)
  ) u_strap (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .strap_in(strap_raw),
    .strap_out(strap),
    .capture_out(strap_capture)
  );

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic acc_rd;
  logic acc_wr;
  logic acc_miim;
  logic [15:0] acc_wdata;
  logic hit_adv;
  logic hit_lp;
  logic hit_exp;

  always_comb begin
    acc_miim = 1'b0;
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_wdata = reg_wdata_in[15:0];
    hit_adv = 1'b0;
    hit_lp = 1'b0;
    hit_exp = 1'b0;
    if (reg_rd_in || reg_wr_in) begin
      acc_rd = reg_rd_in;
      acc_wr = reg_wr_in & ~reg_rd_in;
      hit_adv = (reg_addr_in == epl_pkg::ADV_OFFSET);
      hit_lp = (reg_addr_in == epl_pkg::LP_OFFSET);
      hit_exp = (reg_addr_in == epl_pkg::EXP_OFFSET);
    end else if (miim_rd_in || miim_wr_in) begin
      acc_miim = 1'b1;
      acc_rd = miim_rd_in;
      acc_wr = miim_wr_in & ~miim_rd_in;
      acc_wdata = miim_wdata_in;
      hit_adv = (miim_index_in == epl_pkg::ADV_INDEX);
      hit_lp = (miim_index_in == epl_pkg::LP_INDEX);
      hit_exp = (miim_index_in == epl_pkg::EXP_INDEX);
    end
  end

  // ----------------------------------------
  // Local advertisement
  // ----------------------------------------
  logic [15:0] adv;
  logic [15:0] next_adv;

  always_comb begin
    next_adv = adv;
    if (strap_capture) begin
      next_adv[epl_pkg::SYM_PAUSE_BIT] = ~strap[epl_pkg::STRAP_MANUAL_FC];
      next_adv[epl_pkg::ASYM_PAUSE_BIT] = ~strap[epl_pkg::STRAP_MANUAL_FC];
    end else if (acc_wr && hit_adv) begin
      next_adv = (adv & ~epl_pkg::ADV_WR_MASK) | (acc_wdata & epl_pkg::ADV_WR_MASK);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      adv <= epl_pkg::ADV_RESET;
    end else begin
      adv <= next_adv;
    end
  end

  // ----------------------------------------
  // Partner calculation
  // ----------------------------------------
  logic calc_sym;
  logic calc_asym;
  logic [3:0] calc_abil;
  logic calc_fail;

  epl_partner_calc u_calc (
    .adv_sym_in(adv[epl_pkg::SYM_PAUSE_BIT]),
    .adv_asym_in(adv[epl_pkg::ASYM_PAUSE_BIT]),
    .adv_abil_in(adv[epl_pkg::ABIL_MSB:epl_pkg::ABIL_LSB]),
    .fdfc_strap_in(strap[epl_pkg::STRAP_FDFC]),
    .duplex_pin_in(port0_duplex_input_in),
    .duplex_pol_in(strap[epl_pkg::STRAP_DUP_POL]),
    .speed_strap_in(strap[epl_pkg::STRAP_SPEED]),
    .lp_sym_out(calc_sym),
    .lp_asym_out(calc_asym),
    .lp_abil_out(calc_abil),
    .an_fail_out(calc_fail)
  );

  // ----------------------------------------
  // Negotiation sequence and results
  // ----------------------------------------
  epl_pkg::epl_an_state_type state;
  epl_pkg::epl_an_state_type next_state;
  logic lp_sym;
  logic next_lp_sym;
  logic lp_asym;
  logic next_lp_asym;
  logic lp_an_able;
  logic next_lp_an_able;
  logic page_rx;
  logic next_page_rx;
  logic page_set;

  always_comb begin
    next_state = state;
    next_lp_sym = lp_sym;
    next_lp_asym = lp_asym;
    next_lp_an_able = lp_an_able;
    page_set = 1'b0;
    unique case (state)
      epl_pkg::AN_WAIT_STRAP: begin
        if (strap_capture) begin
          next_state = epl_pkg::AN_RUN;
        end
      end
      epl_pkg::AN_RUN: begin
        next_lp_sym = calc_sym;
        next_lp_asym = calc_asym;
        next_lp_an_able = ~calc_fail;
        page_set = 1'b1;
        next_state = epl_pkg::AN_DONE;
      end
      epl_pkg::AN_DONE: begin
        if (an_restart_in) begin
          next_state = epl_pkg::AN_RUN;
        end
      end
      default: begin
        next_state = epl_pkg::AN_WAIT_STRAP;
      end
    endcase
  end

  always_comb begin
    next_page_rx = page_rx;
    if (acc_rd && hit_exp) begin
      next_page_rx = 1'b0;
    end
    if (page_set) begin
      next_page_rx = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state <= epl_pkg::AN_WAIT_STRAP;
      lp_sym <= 1'b0;
      lp_asym <= 1'b0;
      lp_an_able <= 1'b1;
      page_rx <= 1'b0;
    end else begin
      state <= next_state;
      lp_sym <= next_lp_sym;
      lp_asym <= next_lp_asym;
      lp_an_able <= next_lp_an_able;
      page_rx <= next_page_rx;
    end
  end

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  logic [15:0] lp_word;
  logic [15:0] exp_word;
  logic [15:0] sel_word;

  always_comb begin
    lp_word = 16'h0000;
    lp_word[epl_pkg::NEXT_PAGE_BIT] = 1'b0;
    lp_word[epl_pkg::ACK_BIT] = 1'b1;
    lp_word[epl_pkg::REMOTE_FAULT_BIT] = 1'b0;
    lp_word[epl_pkg::T4_BIT] = 1'b0;
    lp_word[epl_pkg::ASYM_PAUSE_BIT] = lp_asym;
    lp_word[epl_pkg::SYM_PAUSE_BIT] = lp_sym;
    lp_word[epl_pkg::ABIL_MSB:epl_pkg::ABIL_LSB] = calc_abil;
    lp_word[epl_pkg::SEL_MSB:0] = epl_pkg::SELECTOR_8023;
  end

  always_comb begin
    exp_word = 16'h0000;
    exp_word[epl_pkg::EXP_PAR_FAULT_BIT] = 1'b0;
    exp_word[epl_pkg::EXP_LP_NP_BIT] = 1'b0;
    exp_word[epl_pkg::EXP_LOC_NP_BIT] = 1'b0;
    exp_word[epl_pkg::EXP_PAGE_RX_BIT] = page_rx;
    exp_word[epl_pkg::EXP_LP_AN_BIT] = lp_an_able;
  end

  always_comb begin
    sel_word = 16'h0000;
    if (hit_adv) begin
      sel_word = adv;
    end else if (hit_lp) begin
      sel_word = lp_word;
    end else if (hit_exp) begin
      sel_word = exp_word;
    end
  end

  // ----------------------------------------
  // Read return
  // ----------------------------------------
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic [15:0] mdata;
  logic [15:0] next_mdata;
  logic mvalid;
  logic next_mvalid;

  always_comb begin
    next_rdata = rdata;
    next_mdata = mdata;
    next_rvalid = acc_rd & ~acc_miim;
    next_mvalid = acc_rd & acc_miim;
    if (acc_rd && !acc_miim) begin
      next_rdata = {16'h0000, sel_word};
    end
    if (acc_rd && acc_miim) begin
      next_mdata = sel_word;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      rdata <= 32'h0000_0000;
      rvalid <= 1'b0;
      mdata <= 16'h0000;
      mvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      mdata <= next_mdata;
      mvalid <= next_mvalid;
    end
  end

  assign reg_rdata_out = rdata;
  assign reg_rvalid_out = rvalid;
  assign miim_rdata_out = mdata;
  assign miim_rvalid_out = mvalid;
  assign an_complete_out = (state == epl_pkg::AN_DONE);
  assign lp_sym_pause_out = lp_sym;
  assign lp_asym_pause_out = lp_asym;

endmodule // epl_link_partner

// [design/epl_pkg.sv]
package epl_pkg;

  // ----------------------------------------
  // Register byte offsets and serial indices
  // ----------------------------------------
  localparam logic [8:0] ADV_OFFSET = 9'h1d0;
  localparam logic [8:0] LP_OFFSET = 9'h1d4;
  localparam logic [8:0] EXP_OFFSET = 9'h1d8;
  localparam logic [4:0] ADV_INDEX = 5'h04;
  localparam logic [4:0] LP_INDEX = 5'h05;
  localparam logic [4:0] EXP_INDEX = 5'h06;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int NEXT_PAGE_BIT = 15;
  localparam int ACK_BIT = 14;
  localparam int REMOTE_FAULT_BIT = 13;
  localparam int ASYM_PAUSE_BIT = 11;
  localparam int SYM_PAUSE_BIT = 10;
  localparam int T4_BIT = 9;
  localparam int ABIL_MSB = 8;
  localparam int ABIL_LSB = 5;
  localparam int SEL_MSB = 4;
  localparam int EXP_PAR_FAULT_BIT = 4;
  localparam int EXP_LP_NP_BIT = 3;
  localparam int EXP_LOC_NP_BIT = 2;
  localparam int EXP_PAGE_RX_BIT = 1;
  localparam int EXP_LP_AN_BIT = 0;

  // ----------------------------------------
  // Reset values, masks and field codes
  // ----------------------------------------
  localparam logic [15:0] ADV_RESET = 16'h01e1;
  localparam logic [15:0] ADV_WR_MASK = 16'h0dff;
  localparam logic [4:0] SELECTOR_8023 = 5'h01;
  localparam logic [3:0] ABIL_10_FD = 4'h2;
  localparam logic [3:0] ABIL_100_FD = 4'h8;
  localparam logic [3:0] ABIL_10_HD = 4'h1;
  localparam logic [3:0] ABIL_100_HD = 4'h4;

  // ----------------------------------------
  // Strap vector layout
  // ----------------------------------------
  localparam int STRAP_WIDTH = 4;
  localparam int STRAP_FDFC = 0;
  localparam int STRAP_DUP_POL = 1;
  localparam int STRAP_SPEED = 2;
  localparam int STRAP_MANUAL_FC = 3;

  // ----------------------------------------
  // Negotiation states
  // ----------------------------------------
  typedef enum logic [1:0] {
    AN_WAIT_STRAP = 2'b00,
    AN_RUN = 2'b01,
    AN_DONE = 2'b10
  } epl_an_state_type;

endpackage

// [design/epl_strap_latch.sv]
`timescale 1ns/100ps

module epl_strap_latch #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] strap_in,
  output logic [WIDTH-1:0] strap_out,
  output logic capture_out
);

  // ----------------------------------------
  // Capture once on the first edge after reset release
  // ----------------------------------------
  logic armed;
  logic next_armed;
  logic [WIDTH-1:0] held;
  logic [WIDTH-1:0] next_held;

  always_comb begin
    next_armed = 1'b0;
    next_held = held;
    if (armed) begin
      next_held = strap_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      armed <= 1'b1;
      held <= '0;
    end else begin
      armed <= next_armed;
      held <= next_held;
    end
  end

  assign strap_out = held;
  assign capture_out = armed & resetn_in;

endmodule // epl_strap_latch

// [design/epl_partner_calc.sv]
`timescale 1ns/100ps

module epl_partner_calc (
  input wire logic adv_sym_in,
  input wire logic adv_asym_in,
  input wire logic [3:0] adv_abil_in,
  input wire logic fdfc_strap_in,
  input wire logic duplex_pin_in,
  input wire logic duplex_pol_in,
  input wire logic speed_strap_in,
  output logic lp_sym_out,
  output logic lp_asym_out,
  output logic [3:0] lp_abil_out,
  output logic an_fail_out
);

  // ----------------------------------------
  // Partner pause answer
  // ----------------------------------------
  always_comb begin
    unique case ({adv_sym_in, adv_asym_in})
      2'b00: begin
        lp_sym_out = 1'b0;
        lp_asym_out = 1'b0;
      end
      2'b10: begin
        lp_sym_out = 1'b1;
        lp_asym_out = 1'b0;
      end
      2'b01: begin
        lp_sym_out = 1'b1;
        lp_asym_out = 1'b1;
      end
      2'b11: begin
        lp_sym_out = fdfc_strap_in;
        lp_asym_out = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Partner speed and duplex
  // ----------------------------------------
  always_comb begin
    if (duplex_pin_in == duplex_pol_in) begin
      lp_abil_out = speed_strap_in ? epl_pkg::ABIL_100_FD : epl_pkg::ABIL_10_FD;
    end else begin
      lp_abil_out = speed_strap_in ? epl_pkg::ABIL_100_HD : epl_pkg::ABIL_10_HD;
    end
  end

  assign an_fail_out = ((adv_abil_in & lp_abil_out) == 4'h0);

endmodule // epl_partner_calc

// [verification/epl_host_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Management host, word and serial accesses
// ----------------------------------------
module epl_host_model (
  input wire logic sys_clk_in,
  input wire logic [31:0] reg_rdata_in,
  input wire logic reg_rvalid_in,
  input wire logic [15:0] miim_rdata_in,
  input wire logic miim_rvalid_in,
  output logic reg_rd_out,
  output logic reg_wr_out,
  output logic [8:0] reg_addr_out,
  output logic [31:0] reg_wdata_out,
  output logic miim_rd_out,
  output logic miim_wr_out,
  output logic [4:0] miim_index_out,
  output logic [15:0] miim_wdata_out
);
  initial {reg_rd_out, reg_wr_out, miim_rd_out, miim_wr_out, reg_addr_out, reg_wdata_out,
    miim_index_out, miim_wdata_out} = '0;

  task automatic acc(input logic ser, input logic wr, input logic [1:0] r,
    input logic [31:0] d, output logic [31:0] q);
    logic [8:0] a;
    a = epl_pkg::ADV_OFFSET + {5'h00, r, 2'b00};
    @(posedge sys_clk_in);
    reg_rd_out <= !ser && !wr;
    reg_wr_out <= !ser && wr;
    miim_rd_out <= ser && !wr;
    miim_wr_out <= ser && wr;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    miim_index_out <= epl_pkg::ADV_INDEX + {3'h0, r};
    miim_wdata_out <= d[15:0];
    @(posedge sys_clk_in);
    {reg_rd_out, reg_wr_out, miim_rd_out, miim_wr_out} <= 4'h0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
    miim_index_out <= ~miim_index_out;
    miim_wdata_out <= ~d[15:0];
    #1;
    if (ser) q = miim_rvalid_in ? {16'h0000, miim_rdata_in} : 'x;
    else q = reg_rvalid_in ? reg_rdata_in : 'x;
  endtask
endmodule // epl_host_model

// [verification/epl_link_partner_properties.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module epl_link_partner_checker (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [8:0] reg_addr_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic miim_rd_in,
  input wire logic [4:0] miim_index_in,
  input wire logic [15:0] miim_rdata_out,
  input wire logic miim_rvalid_out,
  input wire logic an_restart_in,
  input wire logic an_complete_out,
  input wire logic lp_sym_pause_out,
  input wire logic lp_asym_pause_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  chk_word_answer:
    assert property (reg_rd_in |=> reg_rvalid_out && reg_rdata_out[31:16] == 16'h0000)
    else $error("word read answer wrong");
  chk_lp_fixed_bits:
    assert property ($past(reg_rd_in) && $past(reg_addr_in) == epl_pkg::LP_OFFSET |->
      reg_rdata_out[15:12] == 4'h4 && !reg_rdata_out[9] && reg_rdata_out[4:0] == 5'h01)
    else $error("partner fixed bits wrong");
  chk_lp_abil_onehot:
    assert property ($past(reg_rd_in) && $past(reg_addr_in) == epl_pkg::LP_OFFSET |->
      $onehot(reg_rdata_out[8:5]))
    else $error("partner ability not one value");
  chk_exp_word_zeros:
    assert property ($past(reg_rd_in) && $past(reg_addr_in) == epl_pkg::EXP_OFFSET |->
      reg_rdata_out[4:2] == 3'h0)
    else $error("expansion fixed bits wrong");
  chk_exp_serial_zeros:
    assert property ($past(miim_rd_in && !reg_rd_in && !reg_wr_in &&
      miim_index_in == epl_pkg::EXP_INDEX) |-> miim_rvalid_out && miim_rdata_out[4:2] == 3'h0)
    else $error("serial expansion read wrong");
  chk_pause_hold:
    assert property (an_complete_out && $past(an_complete_out) |->
      $stable(lp_sym_pause_out) && $stable(lp_asym_pause_out))
    else $error("partner pause moved outside negotiation");
  chk_restart_seq:
    assert property (an_restart_in && an_complete_out |=> !an_complete_out ##1 an_complete_out)
    else $error("restart sequence wrong");
  chk_an_after_reset:
    assert property ($rose(resetn_in) |-> ##[1:4] an_complete_out)
    else $error("negotiation not run after reset");
  chk_reset_quiet:
    assert property (disable iff (1'b0) !resetn_in |=> !an_complete_out && !reg_rvalid_out)
    else $error("outputs active in reset");
endmodule // epl_link_partner_checker

bind epl_link_partner epl_link_partner_checker u_epl_link_partner_checker (.*);

// [verification/emulated_phy_link_partner_autoneg_tb.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Bench
// ----------------------------------------
module emulated_phy_link_partner_autoneg_tb;
  typedef struct packed {logic sym; logic asym; logic dup; logic [15:0] lp;} epl_row_type;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic an_restart_in = 1'b0;
  logic port0_duplex_input_in = 1'b0;
  logic fullduplex_flowctl_latch_in = 1'b1;
  logic duplex_pol_strap_in = 1'b0;
  logic speed_strap_in = 1'b0;
  logic manual_fc_strap_in = 1'b1;
  logic reg_rd_in, reg_wr_in, miim_rd_in, miim_wr_in, reg_rvalid_out, miim_rvalid_out;
  logic an_complete_out, lp_sym_pause_out, lp_asym_pause_out;
  logic [8:0] reg_addr_in;
  logic [4:0] miim_index_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [15:0] miim_wdata_in, miim_rdata_out;
  int err_count = 0;
  int checks_done = 0;
  int k;
  epl_row_type rows [4] = '{'{1'b0, 1'b0, 1'b0, 16'h4041}, '{1'b1, 1'b0, 1'b1, 16'h4421},
    '{1'b0, 1'b1, 1'b0, 16'h4c41}, '{1'b1, 1'b1, 1'b1, 16'h4c21}};

  always #2.5 sys_clk_in = ~sys_clk_in;

  epl_link_partner u_epl_link_partner (.*);
  epl_host_model u_epl_host_model (.sys_clk_in(sys_clk_in), .reg_rdata_in(reg_rdata_out),
    .reg_rvalid_in(reg_rvalid_out), .miim_rdata_in(miim_rdata_out),
    .miim_rvalid_in(miim_rvalid_out), .reg_rd_out(reg_rd_in), .reg_wr_out(reg_wr_in),
    .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in), .miim_rd_out(miim_rd_in),
    .miim_wr_out(miim_wr_in), .miim_index_out(miim_index_in), .miim_wdata_out(miim_wdata_in));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] q);
    checks_done++;
    if (q !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, q);
      err_count++;
    end
  endtask

  task automatic rd_chk(input string n, input logic s, input logic [1:0] r,
    input logic [31:0] e);
    logic [31:0] q;
    u_epl_host_model.acc(s, 1'b0, r, 32'h00000000, q);
    chk(n, e, q);
  endtask

  task automatic wr_reg(input logic s, input logic [1:0] r, input logic [31:0] d);
    logic [31:0] q;
    u_epl_host_model.acc(s, 1'b1, r, d, q);
  endtask

  task automatic renego();
    int i;
    @(posedge sys_clk_in);
    an_restart_in <= 1'b1;
    @(posedge sys_clk_in);
    an_restart_in <= 1'b0;
    #1;
    for (i = 0; i < 8 && an_complete_out !== 1'b1; i++) begin
      @(posedge sys_clk_in);
      #1;
    end
    chk("an_complete", 32'h1, {31'h0, an_complete_out});
  endtask

  task automatic do_reset();
    @(posedge sys_clk_in);
    resetn_in <= 1'b0;
    repeat (20) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk_in);
    err_count++;
    test_done();
  end

  initial begin
    do_reset();
    rd_chk("exp_reset", 1'b0, 2'd2, 32'h00000003);
    rd_chk("exp_cleared", 1'b1, 2'd2, 32'h00000001);
    rd_chk("unmapped", 1'b0, 2'd3, 32'h00000000);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      @(posedge sys_clk_in);
      port0_duplex_input_in <= rows[k].dup;
      wr_reg(k[0], 2'd0, {20'h0, rows[k].asym, rows[k].sym, 10'h1e1});
      renego();
      rd_chk("lp_word", k[0], 2'd1, {16'h0, rows[k].lp});
      chk("lp_pause", {30'h0, rows[k].lp[10], rows[k].lp[11]},
        {30'h0, lp_sym_pause_out, lp_asym_pause_out});
    end
    $display("test pause table done");
    wr_reg(1'b0, 2'd0, 32'h000001e1);
    rd_chk("lp_frozen", 1'b0, 2'd1, 32'h00004c21);
    wr_reg(1'b1, 2'd0, 32'h00000001);
    renego();
    rd_chk("exp_fail", 1'b1, 2'd2, 32'h00000002);
    $display("test freeze and fail done");
    @(posedge sys_clk_in);
    speed_strap_in <= 1'b1;
    duplex_pol_strap_in <= 1'b1;
    fullduplex_flowctl_latch_in <= 1'b0;
    manual_fc_strap_in <= 1'b0;
    wr_reg(1'b0, 2'd0, 32'h00000de1);
    renego();
    rd_chk("lp_straps_held", 1'b0, 2'd1, 32'h00004c21);
    do_reset();
    rd_chk("adv_strap", 1'b0, 2'd0, 32'h00000de1);
    rd_chk("lp_new_straps", 1'b1, 2'd1, 32'h00004901);
    chk("lp_pause_out", 32'h1, {30'h0, lp_sym_pause_out, lp_asym_pause_out});
    wr_reg(1'b0, 2'd0, 32'hffffffff);
    rd_chk("adv_ro_bits", 1'b1, 2'd0, 32'h00000dff);
    wr_reg(1'b0, 2'd1, 32'h00000000);
    rd_chk("lp_read_only", 1'b0, 2'd1, 32'h00004901);
    $display("test strap capture done");
    test_done();
  end
endmodule // emulated_phy_link_partner_autoneg_tb
